// file: verilog/bsp_pkg.sv
// Shared constants, carrier structs and state codes of the buffered serial port.
package bsp_pkg;

   // -------------------------------------------------------------------------
   // Sizes and timing
   // -------------------------------------------------------------------------
   localparam int         WORD_W         = 8;
   localparam int         FIFO_DEPTH     = 16;
   localparam int         MCLK_HZ        = 10_000_000;
   localparam int         SYNC_STAGES    = 2;
   localparam logic [7:0] FG_PERIOD_LAST = 8'h0f;

   // -------------------------------------------------------------------------
   // Field codes and reset values
   // -------------------------------------------------------------------------
   localparam logic [1:0] CLKSTOP_NODELAY = 2'h2;
   localparam logic [1:0] CLKSTOP_DELAY   = 2'h3;
   localparam logic [1:0] DATA_DELAY_NONE = 2'h0;
   localparam logic [3:0] CTRL_RESET      = 4'h0;

   // -------------------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic frame_gen_reset_n;
      logic rate_gen_reset_n;
      logic transmitter_reset_n;
      logic receiver_reset_n;
   } bsp_ctrl_s;

   typedef struct packed {
      logic [1:0] clock_stop_select;
      logic [7:0] rate_divider;
      logic [1:0] tx_data_delay;
      logic [1:0] rx_data_delay;
      logic       tx_sync_source_select;
      logic       tx_sync_polarity;
      logic       rx_sync_polarity;
      logic       tx_clk_internal;
      logic       tx_fs_internal;
      logic       rx_clk_internal;
      logic       rx_fs_internal;
   } bsp_cfg_s;

   typedef struct packed {
      logic rx_overrun_flag;
      logic rx_word_ready;
      logic rx_sync_error;
      logic tx_shift_empty_n;
      logic tx_word_ready;
      logic tx_sync_error;
   } bsp_status_s;

   typedef struct packed {
      logic rx_rate;
      logic rx_frame;
      logic tx_rate;
      logic tx_frame;
   } bsp_usage_s;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE  = 3'b100
   } bsp_spi_e;

endpackage

// file: verilog/bsp_fifo.sv
// Receive word FIFO with registered read data.
module bsp_fifo #(
   parameter int WIDTH = bsp_pkg::WORD_W,
   parameter int DEPTH = bsp_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("bsp_fifo: DEPTH must be a power of two");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic                        ov;
      logic [WIDTH-1:0]            dout;
   } bsp_fifo_s;

   bsp_fifo_s st_r;
   bsp_fifo_s st_nxt;
   logic      push;
   logic      load;

   // The output register counts as one extra slot, so capacity is DEPTH+1.
   assign in_ready  = (st_r.cnt != CNT_FULL);
   assign out_valid = st_r.ov;
   assign out_data  = st_r.dout;

   always_comb begin
      st_nxt = st_r;
      push   = in_valid && in_ready;
      load   = (st_r.cnt != '0) && (!st_r.ov || out_ready);
      if (load) begin
         st_nxt.dout = st_r.mem[st_r.rp];
         st_nxt.rp   = st_r.rp + 1'b1;
      end
      st_nxt.ov = load || (st_r.ov && !out_ready);
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data;
         st_nxt.wp           = st_r.wp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      if (flush) begin
         st_nxt.wp  = '0;
         st_nxt.rp  = '0;
         st_nxt.cnt = '0;
         st_nxt.ov  = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // bsp_fifo

// file: verilog/bsp_port.sv
// Buffered serial port core: resets, shared generators, pin drive and SPI-slave engine.
// Summary of operation
// [R01] SPI slave: transmit bit clock pin also clocks the receiver internally.
// [R02] SPI slave: transmit frame-sync pin acts as receive frame sync internally.
// [R03] SPI slave logic runs only with the rate generator running, ideally at half rate.
// [R04] Master must give a fresh slave-enable active edge for every transfer.
// [R05] SPI slave needs both data delays at zero; other values are undefined.
// [R06] Device reset returns the engine to idle and clears counters and status flags; section resets idle the engine only when both are in reset.
// [R07] After device reset all four section reset bits read zero.
// [R08] Transmitter, receiver and rate generator each have an independent reset bit.
// [R09] During device reset clock and frame pins are inputs, serial out floats.
// [R10] Section reset stops activity; output frame sync sits at its polarity level.
// [R11] Output bit clocks keep running from the rate generator during section reset.
// [R12] Serial out is high impedance while the transmitter is in reset.
// [R13] Rate generator reset drives generator clock and generated frame sync low.
// [R14] Software resets the rate generator only while no section uses it.
// [R15] Generated frame sync stays inactive for a section that is in reset.
// [R16] Emulator soft reset restores all port control values to defaults.
// [R17] Receiver generator use follows its clock and frame-sync sources.
// [R18] Internal transmit frame sync comes from frame generator or each holding copy.
// [R19] External clock with internal frame sync works only with per-copy frame sync.
// [R20] Transmitter uses rate generator only with internal clock, frame generator only when it sources internal frame sync.
// [R21] Clock-stop select 2h or 3h chooses SPI mode without or with clock delay.
// [R22] Divider value one makes the generator clock half the input clock.
// [R23] Master clock and slave enable pass two generator-clocked flops before edge use.
module bsp_port #(
   parameter int WORD_W     = bsp_pkg::WORD_W,
   parameter int FIFO_DEPTH = bsp_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                reset_n,
   // Software control and status
   input  wire logic                ctrl_wr,
   input  wire bsp_pkg::bsp_ctrl_s  ctrl_wdata,
   input  wire logic                emu_soft_reset,
   input  wire bsp_pkg::bsp_cfg_s   cfg,
   output bsp_pkg::bsp_ctrl_s       ctrl_rd,
   output bsp_pkg::bsp_status_s     status,
   output bsp_pkg::bsp_usage_s      gen_usage,
   output logic                     cfg_error,
   // Transmit word input
   input  wire logic                tx_wvalid,
   input  wire logic [WORD_W-1:0]   tx_wdata,
   // Receive word output
   output logic                     rx_rvalid,
   input  wire logic                rx_rready,
   output logic [WORD_W-1:0]        rx_rdata,
   // Transmit clock and frame pins
   input  wire logic                tx_bit_clock_pin_i,
   output logic                     tx_bit_clock_pin_o,
   output logic                     tx_bit_clock_pin_oe_n,
   input  wire logic                tx_frame_sync_pin_i,
   output logic                     tx_frame_sync_pin_o,
   output logic                     tx_frame_sync_pin_oe_n,
   // Receive clock and frame pins
   input  wire logic                rx_bit_clock_i,
   output logic                     rx_bit_clock_o,
   output logic                     rx_bit_clock_oe_n,
   input  wire logic                rx_frame_sync_i,
   output logic                     rx_frame_sync_o,
   output logic                     rx_frame_sync_oe_n,
   // Data and clock source pins
   input  wire logic                ext_clock_source_pin,
   input  wire logic                serial_in_pin,
   output logic                     serial_out_pin_o,
   output logic                     serial_out_pin_oe_n
);

   localparam int              BW       = (WORD_W > 2) ? $clog2(WORD_W) : 1;
   localparam logic [BW-1:0]   BIT_LAST = BW'(WORD_W - 1);

   if (WORD_W < 2 || WORD_W > 32) begin : g_bad_width
      $error("bsp_port: WORD_W must be 2 to 32");
   end

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      bsp_pkg::bsp_ctrl_s  ctrl;
      logic [7:0]          div_cnt;
      logic                rate_gen_clock;
      logic [7:0]          fg_cnt;
      logic                rate_gen_frame_sync;
      logic [bsp_pkg::SYNC_STAGES:0] sclk_sy;
      logic [bsp_pkg::SYNC_STAGES:0] ss_sy;
      bsp_pkg::bsp_spi_e   state;
      logic                smp;
      logic [BW-1:0]       bit_cnt;
      logic [WORD_W-1:0]   rx_sh;
      logic [WORD_W-1:0]   tx_sh;
      logic [WORD_W-1:0]   tx_hold;
      logic                hold_full;
      logic                sh_full;
      logic                copy_fs;
      logic                push;
      logic                txrdy;
      logic                rx_ovr;
      logic                rx_serr;
      logic                tx_serr;
      logic                txck_o;
      logic                txck_oe_n;
      logic                txfs_o;
      logic                txfs_oe_n;
      logic                rxck_o;
      logic                rxck_oe_n;
      logic                rxfs_o;
      logic                rxfs_oe_n;
      logic                dx_o;
      logic                dx_oe_n;
      bsp_pkg::bsp_usage_s use_g;
      logic                cfg_err;
   } bsp_state_s;

   // Pins come out of reset as inputs and the data pin floats.
   localparam bsp_state_s ST_RST = '{state: bsp_pkg::ST_IDLE, txck_oe_n: 1'b1, txfs_oe_n: 1'b1,
                                     rxck_oe_n: 1'b1, rxfs_oe_n: 1'b1, dx_oe_n: 1'b1, default: '0};

   bsp_state_s st_r;
   bsp_state_s st_nxt;
   logic       rg_run;
   logic       tx_en;
   logic       rx_en;
   logic       spi;
   logic       spi_ok;
   logic       sel_fg;
   logic       tick;
   logic       sck_rise;
   logic       sck_fall;
   logic       act;
   logic       start;
   logic       drv;
   logic       smp_ev;
   logic       fs_act;
   logic       fifo_in_rdy;

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   always_comb begin
      st_nxt   = st_r;
      rg_run   = st_r.ctrl.rate_gen_reset_n;
      tx_en    = st_r.ctrl.transmitter_reset_n;
      rx_en    = st_r.ctrl.receiver_reset_n;
      spi      = cfg.clock_stop_select[1] && !cfg.tx_clk_internal && !cfg.tx_fs_internal; // [R21]
      spi_ok   = (cfg.tx_data_delay == bsp_pkg::DATA_DELAY_NONE)
              && (cfg.rx_data_delay == bsp_pkg::DATA_DELAY_NONE);
      sel_fg   = cfg.tx_sync_source_select && cfg.tx_clk_internal; // [R19]
      tick     = rg_run && (st_r.div_cnt == cfg.rate_divider);
      sck_rise = st_r.sclk_sy[1] && !st_r.sclk_sy[2]; // [R23]
      sck_fall = !st_r.sclk_sy[1] && st_r.sclk_sy[2];
      act      = st_r.ss_sy[1] ^ cfg.tx_sync_polarity; // [R02]
      start    = tick && act && !(st_r.ss_sy[2] ^ cfg.tx_sync_polarity); // [R04]
      drv      = tick && (spi ? (cfg.clock_stop_select[0] ? sck_rise : sck_fall)
                              : (cfg.tx_clk_internal || sck_fall));
      smp_ev   = tick && spi && (cfg.clock_stop_select[0] ? sck_fall : sck_rise); // [R01]
      st_nxt.push = 1'b0;

      // Software writes; the emulator reset restores the default value.
      if (ctrl_wr) begin
         st_nxt.ctrl = ctrl_wdata; // [R08]
      end
      if (emu_soft_reset) begin
         st_nxt.ctrl = bsp_pkg::CTRL_RESET; // [R16]
      end

      // Rate and frame generators.
      if (!rg_run) begin
         st_nxt.div_cnt = '0; // [R13]
         st_nxt.rate_gen_clock    = 1'b0;
         st_nxt.fg_cnt  = '0;
         st_nxt.rate_gen_frame_sync     = 1'b0;
      end else begin
         st_nxt.div_cnt = tick ? 8'h00 : st_r.div_cnt + 8'h01;
         st_nxt.rate_gen_clock    = (st_nxt.div_cnt <= (cfg.rate_divider >> 1)); // [R22]
         if (!st_r.ctrl.frame_gen_reset_n) begin
            st_nxt.fg_cnt = '0;
            st_nxt.rate_gen_frame_sync    = 1'b0;
         end else if (tick) begin
            st_nxt.rate_gen_frame_sync    = (st_r.fg_cnt == 8'h00);
            st_nxt.fg_cnt = (st_r.fg_cnt == bsp_pkg::FG_PERIOD_LAST) ? 8'h00 : st_r.fg_cnt + 8'h01;
         end
      end

      // The external clock and enable are asynchronous, so they are resampled on generator ticks.
      if (tick) begin
         st_nxt.sclk_sy = {st_r.sclk_sy[1:0], tx_bit_clock_pin_i}; // [R03] [R23]
         st_nxt.ss_sy   = {st_r.ss_sy[1:0], tx_frame_sync_pin_i};
      end

      // Holding register accepts a word whenever it advertises ready.
      if (tx_wvalid && st_r.txrdy) begin
         st_nxt.tx_hold   = tx_wdata;
         st_nxt.hold_full = 1'b1;
      end

      case (st_r.state)
         bsp_pkg::ST_IDLE: begin
            if (spi && spi_ok && start && (rx_en || tx_en)) begin
               if (tx_en) begin
                  st_nxt.tx_sh     = st_r.hold_full ? st_r.tx_hold : st_r.tx_sh;
                  st_nxt.sh_full   = st_r.hold_full;
                  st_nxt.hold_full = 1'b0;
               end
               st_nxt.state   = bsp_pkg::ST_SHIFT;
               st_nxt.bit_cnt = '0;
               st_nxt.smp     = 1'b0;
            end else if (!spi && tx_en && cfg.tx_fs_internal && !sel_fg && st_r.hold_full && tick) begin
               st_nxt.tx_sh     = st_r.tx_hold; // [R18] [R19]
               st_nxt.sh_full   = 1'b1;
               st_nxt.hold_full = 1'b0;
               st_nxt.copy_fs   = 1'b1;
               st_nxt.state     = bsp_pkg::ST_SHIFT;
               st_nxt.bit_cnt   = '0;
            end
         end
         bsp_pkg::ST_SHIFT: begin
            if (tick) begin
               st_nxt.copy_fs = 1'b0;
            end
            if (spi && (!act || !spi_ok)) begin
               // Enable dropped inside a word: the word is abandoned and flagged.
               st_nxt.rx_serr = st_r.rx_serr || (rx_en && act == 1'b0);
               st_nxt.tx_serr = st_r.tx_serr || (tx_en && act == 1'b0);
               st_nxt.state   = bsp_pkg::ST_IDLE; // [R05]
            end else if (smp_ev) begin
               st_nxt.rx_sh = {st_r.rx_sh[WORD_W-2:0], serial_in_pin};
               st_nxt.smp   = 1'b1;
               if (st_r.bit_cnt == BIT_LAST) begin
                  st_nxt.push    = rx_en;
                  st_nxt.sh_full = 1'b0;
                  st_nxt.state   = bsp_pkg::ST_DONE;
               end else begin
                  st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
               end
            end else if (drv && (st_r.smp || !spi)) begin
               // Shifting waits for a sample first, which serves both clock-delay settings.
               st_nxt.smp = 1'b0;
               if (!spi && st_r.bit_cnt == BIT_LAST) begin
                  st_nxt.sh_full = 1'b0;
                  st_nxt.state   = bsp_pkg::ST_IDLE;
               end else begin
                  st_nxt.tx_sh = {st_r.tx_sh[WORD_W-2:0], 1'b0};
                  if (!spi) begin
                     st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
                  end
               end
            end
         end
         bsp_pkg::ST_DONE: begin
            if (!spi || !act) begin
               st_nxt.state = bsp_pkg::ST_IDLE; // [R04]
            end
         end
         default: begin
            st_nxt.state = bsp_pkg::ST_IDLE;
         end
      endcase

      // A full FIFO drops the word and raises the overrun flag.
      if (st_r.push && !fifo_in_rdy) begin
         st_nxt.rx_ovr = 1'b1;
      end

      // Section resets clear their own flags only and leave the other section running.
      if (!tx_en) begin
         st_nxt.hold_full = 1'b0; // [R06] [R08] [R10]
         st_nxt.sh_full   = 1'b0;
         st_nxt.copy_fs   = 1'b0;
         st_nxt.tx_serr   = 1'b0;
      end
      if (!rx_en) begin
         st_nxt.rx_ovr  = 1'b0; // [R06] [R08]
         st_nxt.rx_serr = 1'b0;
         st_nxt.push    = 1'b0;
      end
      if (!tx_en && !rx_en) begin
         st_nxt.state   = bsp_pkg::ST_IDLE; // [R06]
         st_nxt.bit_cnt = '0;
      end
      st_nxt.txrdy = st_nxt.ctrl.transmitter_reset_n && !st_nxt.hold_full;

      // Pin drive.
      fs_act           = tx_en && (sel_fg ? st_nxt.rate_gen_frame_sync : st_nxt.copy_fs); // [R15] [R18]
      st_nxt.txck_oe_n = !cfg.tx_clk_internal;
      st_nxt.txck_o    = st_nxt.rate_gen_clock; // [R11]
      st_nxt.rxck_oe_n = spi || !cfg.rx_clk_internal; // [R01]
      st_nxt.rxck_o    = st_nxt.rate_gen_clock; // [R11]
      st_nxt.txfs_oe_n = !cfg.tx_fs_internal;
      st_nxt.txfs_o    = cfg.tx_sync_polarity ^ fs_act; // [R10]
      st_nxt.rxfs_oe_n = spi || !cfg.rx_fs_internal; // [R02]
      st_nxt.rxfs_o    = cfg.rx_sync_polarity ^ (rx_en && st_nxt.rate_gen_frame_sync); // [R10] [R15]
      st_nxt.dx_oe_n   = !(tx_en && (!spi || act)); // [R12]
      st_nxt.dx_o      = st_nxt.tx_sh[WORD_W-1];

      // Generator usage and configuration check.
      st_nxt.use_g.rx_rate  = !spi && (cfg.rx_clk_internal || cfg.rx_fs_internal); // [R17]
      st_nxt.use_g.rx_frame = !spi && cfg.rx_fs_internal; // [R17]
      st_nxt.use_g.tx_rate  = cfg.tx_clk_internal; // [R20]
      st_nxt.use_g.tx_frame = sel_fg && cfg.tx_fs_internal; // [R18] [R20]
      st_nxt.cfg_err = (spi && !spi_ok) || (!cfg.tx_clk_internal && cfg.tx_fs_internal
                                            && cfg.tx_sync_source_select); // [R05] [R19]
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         st_r <= ST_RST; // [R06] [R07] [R09]
      end else begin
         st_r <= st_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Receive FIFO
   // -------------------------------------------------------------------------
   bsp_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (mclk),
      .reset_n   (reset_n),
      .flush     (!st_r.ctrl.receiver_reset_n),
      .in_valid  (st_r.push),
      .in_ready  (fifo_in_rdy),
      .in_data   (st_r.rx_sh),
      .out_valid (rx_rvalid),
      .out_ready (rx_rready),
      .out_data  (rx_rdata)
   );

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign ctrl_rd                 = st_r.ctrl;
   assign status.rx_overrun_flag  = st_r.rx_ovr;
   assign status.rx_word_ready    = rx_rvalid;
   assign status.rx_sync_error    = st_r.rx_serr;
   assign status.tx_shift_empty_n = st_r.sh_full;
   assign status.tx_word_ready    = st_r.txrdy;
   assign status.tx_sync_error    = st_r.tx_serr;
   assign gen_usage               = st_r.use_g;
   assign cfg_error               = st_r.cfg_err;
   assign tx_bit_clock_pin_o      = st_r.txck_o;
   assign tx_bit_clock_pin_oe_n   = st_r.txck_oe_n;
   assign tx_frame_sync_pin_o     = st_r.txfs_o;
   assign tx_frame_sync_pin_oe_n  = st_r.txfs_oe_n;
   assign rx_bit_clock_o          = st_r.rxck_o;
   assign rx_bit_clock_oe_n       = st_r.rxck_oe_n;
   assign rx_frame_sync_o         = st_r.rxfs_o;
   assign rx_frame_sync_oe_n      = st_r.rxfs_oe_n;
   assign serial_out_pin_o        = st_r.dx_o;
   assign serial_out_pin_oe_n     = st_r.dx_oe_n;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_ctrl_reset_zero: assert property ($past(reset_n) == 1'b0 |-> st_r.ctrl == '0) // [R07]
      else $error("control bits not zero after reset");
   a_dx_tx_reset: assert property (!st_r.ctrl.transmitter_reset_n |=> st_r.dx_oe_n) // [R12]
      else $error("serial out driven while transmitter in reset");
   a_rg_reset_low: assert property (!st_r.ctrl.rate_gen_reset_n |=> !st_r.rate_gen_clock && !st_r.rate_gen_frame_sync) // [R13]
      else $error("generator outputs not low in reset");
   a_div_two_toggle: assert property (st_r.ctrl.rate_gen_reset_n && $past(st_r.ctrl.rate_gen_reset_n, 2) // [R22]
      && $past(st_r.ctrl.rate_gen_reset_n) && cfg.rate_divider == 8'h01 && $past(cfg.rate_divider) == 8'h01
      |-> st_r.rate_gen_clock != $past(st_r.rate_gen_clock)) else $error("divider one does not halve the clock");
   a_spi_rx_input: assert property (spi |=> st_r.rxck_oe_n && st_r.rxfs_oe_n) // [R01]
      else $error("receive pins driven in SPI slave mode");
   a_fs_idle_level: assert property (!st_r.ctrl.transmitter_reset_n |=> st_r.txfs_o == $past(cfg.tx_sync_polarity)) // [R10]
      else $error("frame sync not at inactive level in reset");
   a_rx_flags_clr: assert property (!st_r.ctrl.receiver_reset_n |=> !st_r.rx_ovr && !st_r.rx_serr ##1 !rx_rvalid) // [R06]
      else $error("receive status not cleared by reset");
   a_sync_on_tick: assert property (!tick |=> $stable(st_r.sclk_sy) && $stable(st_r.ss_sy)) // [R23]
      else $error("synchroniser moved without generator tick");
   a_bad_delay_idle: assert property (spi && !spi_ok && st_r.state == bsp_pkg::ST_IDLE // [R05]
      |=> st_r.state == bsp_pkg::ST_IDLE) else $error("transfer started with nonzero data delay");
   a_fg_inactive: assert property (!st_r.ctrl.receiver_reset_n && rg_run |=> // [R15]
      st_r.rxfs_o == $past(cfg.rx_sync_polarity)) else $error("generated frame sync reached reset receiver");

endmodule // bsp_port

// file: verification/bsp_spi_master.sv
// SPI master model that drives the port's slave-side pins.
module bsp_spi_master (
   // Clock
   input  wire logic mclk,
   // Slave-side pins
   output logic      sclk,
   output logic      ss_n,
   output logic      mosi,
   input  wire logic miso
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end
   // Sample on the rising clock edge, or on the falling one in the delayed mode.
   // The clock stands still between packets.
   task automatic xfer(input logic late, input logic [7:0] d, output logic [7:0] q);
      ss_n <= 1'b0;
      repeat (16) @(posedge mclk);
      for (int i = 7; i >= 0; i--) begin
         mosi <= d[i];
         repeat (6) @(posedge mclk);
         sclk <= 1'b1;
         if (!late) q[i] = miso;
         repeat (12) @(posedge mclk);
         if (late) q[i] = miso;
         sclk <= 1'b0;
         repeat (6) @(posedge mclk);
      end
      ss_n <= 1'b1;
      mosi <= ~mosi;
      repeat (16) @(posedge mclk);
   endtask
endmodule // bsp_spi_master

// file: verification/bsp_port_tb_top.sv
// Self-checking bench for the buffered serial port core.
module bsp_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, reset_n = 1'b0, ctrl_wr = 1'b0, emu_soft_reset = 1'b0, tx_wvalid = 1'b0, rx_rready = 1'b0;
   bsp_pkg::bsp_ctrl_s   ctrl_wdata = 4'h0, ctrl_rd;
   bsp_pkg::bsp_cfg_s    cfg = '0;
   bsp_pkg::bsp_status_s status;
   bsp_pkg::bsp_usage_s  gen_usage;
   logic [7:0] tx_wdata = 8'h00, rx_rdata, d, q;
   logic cfg_error, rx_rvalid, tx_bit_clock_pin_o, tx_bit_clock_pin_oe_n, tx_frame_sync_pin_o, tx_frame_sync_pin_oe_n;
   logic rx_bit_clock_o, rx_bit_clock_oe_n, rx_frame_sync_o, rx_frame_sync_oe_n, serial_out_pin_o, serial_out_pin_oe_n;
   logic tx_bit_clock_pin_i, tx_frame_sync_pin_i, serial_in_pin;
   logic rx_bit_clock_i = 1'b0, rx_frame_sync_i = 1'b0, ext_clock_source_pin = 1'b0;
   int   fails = 0, n_compared = 0;
   bsp_port DUT (.*);
   bsp_spi_master M (.mclk, .sclk(tx_bit_clock_pin_i), .ss_n(tx_frame_sync_pin_i), .mosi(serial_in_pin),
                     .miso(serial_out_pin_o));
   initial forever #50 mclk = ~mclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] v);
      ctrl_wr <= 1'b1;
      ctrl_wdata <= v;
      @(posedge mclk);
      ctrl_wr <= 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check(ctrl_rd, v);
      @(posedge mclk);
   endtask
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic bsp_pkg::bsp_usage_s exp_use(input bsp_pkg::bsp_cfg_s c);
      return {c.rx_clk_internal | c.rx_fs_internal, c.rx_fs_internal, c.tx_clk_internal,
              c.tx_clk_internal & c.tx_fs_internal & c.tx_sync_source_select};
   endfunction
   initial begin
      repeat (30000) @(posedge mclk);
      fails++;
      end_of_test();
   end
   initial begin
      void'($urandom(34074));
      repeat (5) @(negedge mclk);
      check({ctrl_rd, status, gen_usage, cfg_error, rx_rvalid}, 0);
      check({tx_bit_clock_pin_oe_n, tx_frame_sync_pin_oe_n, serial_out_pin_oe_n}, 3'h7);
      @(posedge mclk);
      reset_n <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         {cfg.tx_clk_internal, cfg.tx_fs_internal, cfg.rx_clk_internal, cfg.rx_fs_internal} <= i[4:1];
         cfg.tx_sync_source_select <= i[0];
         cfg.tx_sync_polarity <= 1'($urandom);
         repeat (3) @(negedge mclk);
         check(ctrl_rd, 0);
         check(gen_usage, exp_use(cfg));
         check(cfg_error, !cfg.tx_clk_internal & cfg.tx_fs_internal & cfg.tx_sync_source_select);
         if (cfg.tx_fs_internal) check(tx_frame_sync_pin_o, cfg.tx_sync_polarity);
         @(posedge mclk);
      end
      cfg.tx_clk_internal <= 1'b1;
      cfg.tx_fs_internal <= 1'b0;
      cfg.rate_divider <= 8'h01;
      wr(4'h4);
      @(negedge mclk);
      d[0] = tx_bit_clock_pin_o;
      @(negedge mclk);
      check(tx_bit_clock_pin_o, !d[0]);
      check(tx_bit_clock_pin_oe_n, 1'b0);
      @(posedge mclk);
      wr(4'h0);
      @(negedge mclk);
      check(tx_bit_clock_pin_o, 1'b0);
      @(posedge mclk);
      cfg.tx_clk_internal <= 1'b0;
      cfg.tx_sync_polarity <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         cfg.clock_stop_select <= m[0] ? bsp_pkg::CLKSTOP_DELAY : bsp_pkg::CLKSTOP_NODELAY;
         wr(4'h7);
         tx_wdata <= (m == 2) ? 8'h81 : 8'($urandom);
         tx_wvalid <= 1'b1;
         @(posedge mclk);
         tx_wvalid <= 1'b0;
         d = (m == 3) ? 8'h01 : 8'($urandom);
         M.xfer(m[0], d, q);
         check(q, tx_wdata);
         for (int k = 0; k < 40 && rx_rvalid !== 1'b1; k++) @(posedge mclk);
         @(negedge mclk);
         check({rx_rvalid, rx_rdata, status.rx_sync_error}, {1'b1, d, 1'b0});
         @(posedge mclk);
         rx_rready <= 1'b1;
         @(posedge mclk);
         rx_rready <= 1'b0;
      end
      wr(4'h5);
      @(negedge mclk);
      check(serial_out_pin_oe_n, 1'b1);
      @(posedge mclk);
      emu_soft_reset <= 1'b1;
      @(posedge mclk);
      emu_soft_reset <= 1'b0;
      repeat (3) @(negedge mclk);
      check({ctrl_rd, status}, 0);
      end_of_test();
   end
endmodule // bsp_port_tb_top
